// File: rtl/erxfc_top.sv
// Receive-buffer flow control: read pointer, threshold, pause and jam.
// Assumes an AXI4-Lite master and a nibble-wide transmit sink that may
// stall; the remaining-buffer count comes from the buffer allocator.
//
// Design decision made here: the AXI4-Lite slave port.
`default_nettype none
module erxfc_top #(
   parameter int BLOCKS_W   = 8,
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // AXI4-Lite write address
   input  wire logic [11:0]         s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [11:0]         s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // Buffer allocator side
   input  wire logic [BLOCKS_W-1:0] rx_blocks_remaining,
   // Pause frame request to the transmit datapath
   output logic                     pause_req,
   input  wire logic                pause_ack,
   // Jam nibble stream toward the medium
   output logic [3:0]               jam_data,
   output logic                     jam_valid,
   input  wire logic                jam_ready,
   // Pointer seen by the receive datapath
   output logic [15:0]              rx_read_pointer
);
   // Parameters the logic cannot serve raise an error at time zero
   initial begin
      if (BLOCKS_W < erxfc_pkg::THRESH_W || BLOCKS_W > 16)
         $error("erxfc_top: BLOCKS_W must lie in 6..16");
      if (FIFO_DEPTH < 2 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH)
         $error("erxfc_top: FIFO_DEPTH must be a power of two, at least 2");
   end

   typedef enum logic [1:0] {FC_IDLE, FC_PAUSE, FC_WAIT, FC_JAM} erxfc_fc_t;

   function automatic logic hit(input logic [11:0] a, input logic [7:0] i);
      return a[11:2] == {2'b00, i};
   endfunction

   // Registers
   logic [erxfc_pkg::RRP_HIGH_RW_W-1:0] rx_read_pointer_high;
   logic [7:0]                          rx_read_pointer_low;
   logic [erxfc_pkg::THRESH_W-1:0]      flow_threshold_level;
   logic                                full_duplex;
   erxfc_fc_t                           fc_state;
   erxfc_fc_t                           next_fc_state;

   // Bus handshake state
   logic        aw_held;
   logic        w_held;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;

   // Decode
   logic        do_write;
   logic        wr_high;
   logic        wr_low;
   logic        wr_size;
   logic        wr_ctrl;
   logic        wr_mapped;
   logic        rd_take;
   logic        rd_mapped;
   logic [31:0] rd_word;
   logic [7:0]  high_byte;
   logic        below;
   logic        enabled;
   logic        cond;
   logic        rd_high;
   logic        rd_low;
   logic        rd_size;
   logic        rd_ctrl;
   logic        rd_status;
   logic        rd_blocks;
   logic        jamming;
   logic        armed;
   logic        jam_push;

   assign do_write  = aw_held && w_held && !s_axi_bvalid;
   assign wr_high   = hit(aw_addr, erxfc_pkg::IDX_RRP_HIGH);
   assign wr_low    = hit(aw_addr, erxfc_pkg::IDX_RRP_LOW);
   assign wr_size   = hit(aw_addr, erxfc_pkg::IDX_BUF_SIZE);
   assign wr_ctrl   = hit(aw_addr, erxfc_pkg::IDX_CTRL);
   assign wr_mapped = wr_high || wr_low || wr_size || wr_ctrl;
   assign rd_take   = s_axi_arvalid && s_axi_arready;

   // Read decode; an unmapped index answers SLVERR with zero data
   assign rd_high   = hit(s_axi_araddr, erxfc_pkg::IDX_RRP_HIGH);
   assign rd_low    = hit(s_axi_araddr, erxfc_pkg::IDX_RRP_LOW);
   assign rd_size   = hit(s_axi_araddr, erxfc_pkg::IDX_BUF_SIZE);
   assign rd_ctrl   = hit(s_axi_araddr, erxfc_pkg::IDX_CTRL);
   assign rd_status = hit(s_axi_araddr, erxfc_pkg::IDX_STATUS);
   assign rd_blocks = hit(s_axi_araddr, erxfc_pkg::IDX_BLOCKS);

   // Bits 7:5 are hard zero, so they read back as 000
   assign high_byte = {3'b000, rx_read_pointer_high};

   always_comb begin
      rd_word   = 32'h0000_0000;
      rd_mapped = 1'b1;
      if (rd_high)
         rd_word[7:0] = high_byte;
      else if (rd_low)
         rd_word[7:0] = rx_read_pointer_low;
      else if (rd_size)
         rd_word[erxfc_pkg::THRESH_W-1:0] = flow_threshold_level;
      else if (rd_ctrl)
         rd_word[erxfc_pkg::CTRL_DUPLEX_BIT] = full_duplex;
      else if (rd_status) begin
         rd_word[erxfc_pkg::ST_COND_BIT]  = cond;
         rd_word[erxfc_pkg::ST_JAM_BIT]   = jamming;
         rd_word[erxfc_pkg::ST_ARMED_BIT] = armed;
         rd_word[erxfc_pkg::ST_PAUSE_BIT] = pause_req;
      end else if (rd_blocks)
         rd_word[BLOCKS_W-1:0] = rx_blocks_remaining;
      else
         rd_mapped = 1'b0;
   end

   // Write channel: address and data taken in either order
   // Ready pulses once per item so a held half is never overwritten
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= '0;
         w_strb        <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= erxfc_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? erxfc_pkg::RESP_OKAY
                                      : erxfc_pkg::RESP_SLVERR;
         end else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Register stores; only byte lane 0 carries data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_read_pointer_high <=
            erxfc_pkg::RRP_HIGH_RST[erxfc_pkg::RRP_HIGH_RW_W-1:0];
         rx_read_pointer_low  <= erxfc_pkg::RRP_LOW_RST;
         flow_threshold_level <= erxfc_pkg::THRESH_RST;
         full_duplex          <= erxfc_pkg::DUPLEX_RST;
      end else if (do_write && w_strb[0]) begin
         if (wr_high)
            rx_read_pointer_high <=
               w_data[erxfc_pkg::RRP_HIGH_RW_W-1:0];
         if (wr_low)
            rx_read_pointer_low <= w_data[7:0];
         if (wr_size)
            flow_threshold_level <= w_data[erxfc_pkg::THRESH_W-1:0];
         if (wr_ctrl)
            full_duplex <= w_data[erxfc_pkg::CTRL_DUPLEX_BIT];
      end
   end

   // Read channel: one cycle from address to data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= erxfc_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_mapped ? erxfc_pkg::RESP_OKAY
                                      : erxfc_pkg::RESP_SLVERR;
         end else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Pointer driven out from a flop
   always_ff @(posedge aclk) begin
      if (!aresetn)
         rx_read_pointer <= '0;
      else
         rx_read_pointer <= {high_byte, rx_read_pointer_low};
   end

   // Threshold comparison
   assign enabled = (flow_threshold_level != '0);
   assign below   = (rx_blocks_remaining <=
                     BLOCKS_W'(flow_threshold_level));
   assign cond    = enabled && below;

   // Flow-control sequencer. FC_WAIT holds the one-shot disarmed
   // until software frees buffers past the threshold.
   // A duplex change acts only from FC_IDLE, so an event in progress
   // finishes in the mode it started in.
   always_comb begin
      next_fc_state = fc_state;
      case (fc_state)
         FC_IDLE: begin
            if (cond)
               next_fc_state = full_duplex ? FC_PAUSE : FC_JAM;
         end
         FC_PAUSE: begin
            if (pause_ack)
               next_fc_state = FC_WAIT;
         end
         FC_WAIT: begin
            if (!below || !enabled)
               next_fc_state = FC_IDLE;
         end
         FC_JAM: begin
            if (!below || !enabled)
               next_fc_state = FC_IDLE;
         end
         default: next_fc_state = FC_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fc_state  <= FC_IDLE;
         pause_req <= 1'b0;
      end else begin
         fc_state  <= next_fc_state;
         pause_req <= (next_fc_state == FC_PAUSE);
      end
   end

   // State flags for the status word; jamming also drives the jam source
   assign jamming  = (fc_state == FC_JAM);
   assign armed    = (fc_state == FC_IDLE);

   // Jam nibbles flow into the FIFO while jamming; a stalled sink
   // backs up into it and simply pauses the stream.
   assign jam_push = jamming;

   // Fill-side ready stays open: the pattern never changes, so a
   // nibble refused while the buffer is full loses nothing.
   erxfc_fifo #(
      .WIDTH (4),
      .DEPTH (FIFO_DEPTH)
   ) u_jam_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_data   (erxfc_pkg::JAM_NIBBLE),
      .in_valid  (jam_push),
      .in_ready  (),
      .out_data  (jam_data),
      .out_valid (jam_valid),
      .out_ready (jam_ready)
   );

endmodule
`default_nettype wire

// File: rtl/erxfc_pkg.sv
// Package for the receive-buffer flow-control block: register map,
// field layout, reset values and the jam pattern.
// Assumes a 32-bit AXI4-Lite register bus, one aligned word per register.
`default_nettype none
package erxfc_pkg;
   // Printed offsets are not all multiples of four: these are indices
   localparam logic [7:0]  IDX_RRP_HIGH   = 8'h4a;
   localparam logic [7:0]  IDX_RRP_LOW    = 8'h4b;
   localparam logic [7:0]  IDX_BUF_SIZE   = 8'h4c;
   localparam logic [7:0]  IDX_CTRL       = 8'h4d;
   localparam logic [7:0]  IDX_STATUS     = 8'h4e;
   localparam logic [7:0]  IDX_BLOCKS     = 8'h4f;
   // Pointer high byte: bits 7:5 read-only zero
   localparam int          RRP_HIGH_RW_W  = 5;
   localparam logic [7:0]  RRP_HIGH_RST   = 8'h00;
   localparam logic [7:0]  RRP_LOW_RST    = 8'h00;
   // Buffer size register: threshold in the low six bits
   localparam int          THRESH_W       = 6;
   localparam logic [5:0]  THRESH_RST     = 6'h00;
   // Control register: bit 0 full duplex, other bits unused
   localparam int          CTRL_DUPLEX_BIT = 0;
   localparam logic        DUPLEX_RST     = 1'b0;
   // Status bits
   localparam int          ST_COND_BIT    = 0;
   localparam int          ST_JAM_BIT     = 1;
   localparam int          ST_ARMED_BIT   = 2;
   localparam int          ST_PAUSE_BIT   = 3;
   // Jam nibble repeated on the medium
   localparam logic [3:0]  JAM_NIBBLE     = 4'h5;
   localparam logic [1:0]  RESP_OKAY      = 2'b00;
   localparam logic [1:0]  RESP_SLVERR    = 2'b10;
endpackage
`default_nettype wire

// File: rtl/erxfc_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none
module erxfc_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Fill side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // Drain side
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("erxfc_fifo: DEPTH must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             push;
   logic             pop;
   logic             empty;
   logic             full;

   assign empty       = (wr_ptr == rd_ptr);
   assign full        = (wr_ptr[AW] != rd_ptr[AW]) &&
                        (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign push        = in_valid && !full;
   assign pop         = out_valid && out_ready;
   assign next_rd_ptr = rd_ptr + (AW+1)'(pop);
   assign in_ready    = !full;

   always_ff @(posedge aclk) begin
      if (push)
         mem[wr_ptr[AW-1:0]] <= in_data;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= wr_ptr + (AW+1)'(push);
         rd_ptr <= next_rd_ptr;
      end
   end

   // Registered read from the next read pointer: data match the read pointer in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end else if (!out_valid || out_ready) begin
         out_valid <= (wr_ptr != next_rd_ptr) && !(pop && empty);
         out_data  <= mem[next_rd_ptr[AW-1:0]];
      end
   end
endmodule
`default_nettype wire

// File: bench/erxfc_sva.sv
// Checker for the receive flow-control top: pointer, pause and jam.
// Assumes one register write at a time and the bench's bind.
`default_nettype none
module erxfc_sva #(
   parameter int BLOCKS_W = 8
) (
   // Clock, reset and register bus
   input wire logic                aclk,
   input wire logic                aresetn,
   input wire logic [11:0]         s_axi_awaddr,
   input wire logic                s_axi_awvalid,
   input wire logic                s_axi_awready,
   input wire logic [31:0]         s_axi_wdata,
   input wire logic [3:0]          s_axi_wstrb,
   input wire logic                s_axi_wvalid,
   input wire logic                s_axi_wready,
   input wire logic [1:0]          s_axi_bresp,
   input wire logic                s_axi_bvalid,
   // Flow-control side
   input wire logic [BLOCKS_W-1:0] rx_blocks_remaining,
   input wire logic                pause_req,
   input wire logic                pause_ack,
   input wire logic [3:0]          jam_data,
   input wire logic                jam_valid,
   input wire logic                jam_ready,
   input wire logic [15:0]         rx_read_pointer
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] adr;
   logic [7:0]  dat, hi, lo;
   logic [5:0]  thr;
   logic        dup, bv_q, cond_q, wen;
   // Shadow registers commit one edge after the design's own
   wire cond = thr != 6'h00 && rx_blocks_remaining <= BLOCKS_W'(thr);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {hi, lo, thr, dup, bv_q, cond_q, wen} <= '0;
      end else begin
         bv_q <= s_axi_bvalid;
         cond_q <= cond;
         if (s_axi_awvalid && s_axi_awready) adr <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) begin
            dat <= s_axi_wdata[7:0];
            wen <= s_axi_wstrb[0];
         end
         if (s_axi_bvalid && !bv_q && wen && s_axi_bresp == 2'b00) begin
            case (adr)
               12'h128: hi <= dat;
               12'h12c: lo <= dat;
               12'h130: thr <= dat[5:0];
               12'h134: dup <= dat[0];
               default: ;
            endcase
         end
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_ptr_concat: assert property (rx_read_pointer == {3'b000, hi[4:0], lo})
      else $error("read pointer differs from its bytes");
   a_ptr_top_zero: assert property (rx_read_pointer[15:13] == 3'b000)
      else $error("pointer upper bits not zero");
   a_off_quiet: assert property (thr == 6'h00 && !pause_req |=> !pause_req)
      else $error("pause raised with threshold off");
   a_pause_raise: assert property (dup && cond && !cond_q && !pause_req
      && !jam_valid |=> pause_req)
      else $error("pause missing after threshold crossed");
   a_pause_hold: assert property (pause_req && !pause_ack |=> pause_req)
      else $error("pause dropped before acknowledge");
   a_pause_once: assert property (pause_req && pause_ack |=> !pause_req)
      else $error("pause held after acknowledge");
   a_no_rearm: assert property (dup && cond && cond_q && !pause_req
      |=> !pause_req)
      else $error("pause repeated without re-arm");
   a_jam_nibble: assert property (jam_valid |-> jam_data == 4'h5)
      else $error("jam nibble is not five");
   a_jam_start: assert property ((!dup && cond) [*6] |-> jam_valid)
      else $error("no jamming in half duplex");
   a_jam_stop: assert property (!dup && $fell(cond)
      |-> ##[1:100] !jam_valid)
      else $error("jamming did not stop");
endmodule
`default_nettype wire

// File: bench/erxfc_medium_model.sv
// Transmit side toward the medium: takes pause frames and jam nibbles.
// Assumes the bench picks prompt or slow answers between events.
`default_nettype none
module erxfc_medium_model (
   // Clock, reset and speed
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic slow,
   // Pause handshake and jam stream
   input  wire logic pause_req,
   output logic      pause_ack,
   output logic      jam_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt;
   // Slow mode stalls eight of sixteen cycles so the jam FIFO fills
   assign jam_ready = !slow || cnt[3];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 4'h0;
         pause_ack <= 1'b0;
      end else begin
         cnt <= cnt + 4'h1;
         pause_ack <= pause_req && !pause_ack && (!slow || cnt == 4'hf);
      end
   end
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Top bench: drives registers over AXI4-Lite and the buffer count.
// Assumes the partner model answers pause and jam on the far side.
`default_nettype none
bind erxfc_top erxfc_sva #(.BLOCKS_W(BLOCKS_W)) chk (
   .aclk                (aclk),
   .aresetn             (aresetn),
   .s_axi_awaddr        (s_axi_awaddr),
   .s_axi_awvalid       (s_axi_awvalid),
   .s_axi_awready       (s_axi_awready),
   .s_axi_wdata         (s_axi_wdata),
   .s_axi_wstrb         (s_axi_wstrb),
   .s_axi_wvalid        (s_axi_wvalid),
   .s_axi_wready        (s_axi_wready),
   .s_axi_bresp         (s_axi_bresp),
   .s_axi_bvalid        (s_axi_bvalid),
   .rx_blocks_remaining (rx_blocks_remaining),
   .pause_req           (pause_req),
   .pause_ack           (pause_ack),
   .jam_data            (jam_data),
   .jam_valid           (jam_valid),
   .jam_ready           (jam_ready),
   .rx_read_pointer     (rx_read_pointer)
);
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf, jam_data;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b1;
   logic        s_axi_rready = 1'b1, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [7:0]  rx_blocks_remaining = '0, hv, lv;
   logic        pause_req, pause_ack, jam_valid, jam_ready;
   logic [15:0] rx_read_pointer;
   logic [33:0] rq[$];
   logic [1:0]  wq[$];
   logic        pq[$];
   int          mismatches = 0, tests_run = 0, cycles = 0, nib = 0, n;
   int          seed = 85798;
   erxfc_top dut (
      .aclk                (aclk),
      .aresetn             (aresetn),
      .s_axi_awaddr        (s_axi_awaddr),
      .s_axi_awvalid       (s_axi_awvalid),
      .s_axi_awready       (s_axi_awready),
      .s_axi_wdata         (s_axi_wdata),
      .s_axi_wstrb         (s_axi_wstrb),
      .s_axi_wvalid        (s_axi_wvalid),
      .s_axi_wready        (s_axi_wready),
      .s_axi_bresp         (s_axi_bresp),
      .s_axi_bvalid        (s_axi_bvalid),
      .s_axi_bready        (s_axi_bready),
      .s_axi_araddr        (s_axi_araddr),
      .s_axi_arvalid       (s_axi_arvalid),
      .s_axi_arready       (s_axi_arready),
      .s_axi_rdata         (s_axi_rdata),
      .s_axi_rresp         (s_axi_rresp),
      .s_axi_rvalid        (s_axi_rvalid),
      .s_axi_rready        (s_axi_rready),
      .rx_blocks_remaining (rx_blocks_remaining),
      .pause_req           (pause_req),
      .pause_ack           (pause_ack),
      .jam_data            (jam_data),
      .jam_valid           (jam_valid),
      .jam_ready           (jam_ready),
      .rx_read_pointer     (rx_read_pointer)
   );
   erxfc_medium_model far (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .slow      (slow),
      .pause_req (pause_req),
      .pause_ack (pause_ack),
      .jam_ready (jam_ready)
   );
   always #50 aclk = ~aclk;
   task automatic chk(input string nm, input logic [33:0] e,
                      input logic [33:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic conclude();
      if (mismatches == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
                     input logic [1:0] r);
      wq.push_back(r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid && !s_axi_awready
                 || s_axi_wvalid && !s_axi_wready);
      while (!s_axi_bvalid) @(posedge aclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [33:0] e);
      rq.push_back(e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
   endtask
   task automatic blk(input logic [7:0] v, input int w);
      @(posedge aclk);
      rx_blocks_remaining <= v;
      repeat (w) @(posedge aclk);
   endtask
   always @(posedge aclk) begin
      cycles++;
      if (s_axi_rvalid) chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid) chk("bresp", wq.pop_front(), s_axi_bresp);
      if (jam_valid && jam_ready) nib++;
      if (pause_req && pause_ack) begin
         chk("pause_expected", 1'b1, pq.size() != 0);
         if (pq.size() != 0) pq.delete(0);
      end
      if (cycles == 4000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h128, 34'h0);
      for (int i = 0; i < 4; i++) begin
         hv = 8'($random(seed));
         lv = 8'($random(seed));
         wr(12'h128, hv, 2'b00);
         wr(12'h12c, lv, 2'b00);
         rd(12'h128, {26'h0, 3'b000, hv[4:0]});
         chk("pointer", {3'b000, hv[4:0], lv}, rx_read_pointer);
      end
      // Unmapped place answers an error and reads zero
      wr(12'h200, 8'hff, 2'b10);
      rd(12'h200, {2'b10, 32'h0});
      chk("jam_off", 0, nib);
      wr(12'h134, 8'h01, 2'b00);
      blk(8'd20, 20);
      wr(12'h130, 8'h08, 2'b00);
      rd(12'h130, 34'h8);
      rd(12'h134, 34'h1);
      rd(12'h138, 34'h4);
      rd(12'h13c, 34'h14);
      for (int k = 0; k < 2; k++) begin
         slow <= k[0];
         pq.push_back(1'b1);
         blk(8'd8, 50);
         chk("pause_taken", 0, pq.size());
         rd(12'h138, 34'h1);
         // Dipping lower and back to the level must not re-arm
         blk(8'($random(seed) & 7), 10);
         blk(8'd8, 20);
         blk(8'd9, 5);
      end
      wr(12'h134, 8'h00, 2'b00);
      n = nib;
      blk(8'd3, 60);
      chk("jamming", 1'b1, nib > n + 20);
      rd(12'h138, 34'h3);
      blk(8'd8, 30);
      chk("jam_at_level", 1'b1, jam_valid);
      blk(8'd9, 60);
      n = nib;
      repeat (30) @(posedge aclk);
      chk("jam_stopped", n, nib);
      chk("pause_left", 0, pq.size());
      conclude();
   end
endmodule
`default_nettype wire
